// ==== ddrca_consts.svh ====
`ifndef DDRCA_CONSTS_SVH
`define DDRCA_CONSTS_SVH
// ==========================================================
// array organisation
`define DDRCA_BG_W 2
`define DDRCA_BA_W 2
`define DDRCA_BANKS 16
// ==========================================================
// address pin roles
`define DDRCA_ADDR_W 14
`define DDRCA_AP_BIT 10
`define DDRCA_BC_BIT 12
`define DDRCA_COL_W 3
// ==========================================================
// burst and latency
`define DDRCA_BEATS_FULL 8
`define DDRCA_BEATS_CHOP 4
`define DDRCA_LAT_W 7
`define DDRCA_PRE_ONE 7'h01
`define DDRCA_PRE_TWO 7'h02
// ==========================================================
// reset values
`define DDRCA_BANKS_RST 16'h0000
`define DDRCA_SYNC_RST 35'h0
`endif

// ==== ddrca_pkg.sv ====
package ddrca_pkg;
    // power states of the device
    typedef enum logic [1:0] {PWR_ON, PWR_PPD, PWR_APD, PWR_SREF} ddrca_pwr_t;
    // decoded command on a ck rise
    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS
    } ddrca_cmd_t;
    // burst engine
    typedef enum logic [1:0] {BST_IDLE, BST_WAIT, BST_DATA} ddrca_bst_t;
    // additive latency selection
    typedef enum logic [1:0] {AL_ZERO, AL_CL1, AL_CL2} ddrca_al_t;
endpackage

// ==== ddrca_core.sv ====
// Behaviour
// - sixteen banks in four groups, addressed by bank group plus bank
// - each unchopped access is eight half-clock transfers of one byte
// - bursts start at the given column, eight beats or four chopped
// - burst order selectable sequential or interleaved
// - activate takes bank group, bank and sixteen-bit row
// - read/write takes column; A10 requests auto precharge after burst
// - with on-the-fly enabled, A12 low chops the burst to four
// - inputs sampled where ck rises and ck complement falls
// - cke high enables internal clocks, buffers and drivers
// - cke low enters precharge/self-refresh when idle, else active PD
// - self-refresh exit sees cke without any ck edge
// - power-down keeps only clock, termination and cke buffers
// - self-refresh keeps only the cke buffer
// - additive latency of zero, CL-1 or CL-2
// - read strobe preamble of one or two clocks
// - commands with chip select high are ignored
// - precharge closes one bank, or all when A10 high
`timescale 1ns/1ps
`default_nettype none
`include "ddrca_consts.svh"
module ddrca_core
    import ddrca_pkg::*;
#(
    parameter int ROW_W = 16,
    parameter int DQ_W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ckT,
    input wire logic ckC,
    input wire logic cke,
    input wire logic csN,
    input wire logic actN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [`DDRCA_BG_W-1:0] bg,
    input wire logic [`DDRCA_BA_W-1:0] ba,
    input wire logic [`DDRCA_ADDR_W-1:0] addr,
    input wire logic odt,
    input wire logic [DQ_W-1:0] dqIn,
    output logic [DQ_W-1:0] dqOut,
    output logic dqOe,
    output logic dqsOut,
    output logic dqsOe,
    input wire logic [4:0] clLat,
    input wire logic [4:0] cwLat,
    input wire logic [1:0] alMode,
    input wire logic otfEnable,
    input wire logic fixedChop,
    input wire logic burstInterleave,
    input wire logic preambleTwo,
    output logic [1:0] pwrState,
    output logic [`DDRCA_BANKS-1:0] bankOpen,
    output logic intClkOn,
    output logic cmdBufOn,
    output logic ckBufOn,
    output logic odtBufOn,
    output logic odtSeen
);
    localparam int SYNC_W = 21 + `DDRCA_ADDR_W;

    // ==========================================================
    // input synchroniser: every pin crosses two flops
    logic [SYNC_W-1:0] sync1_q, sync2_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= `DDRCA_SYNC_RST;
            sync2_q <= `DDRCA_SYNC_RST;
        end else begin
            sync1_q <= {ckT, ckC, cke, csN, actN, rasN, casN, weN, bg, ba,
                        addr, odt, dqIn};
            sync2_q <= sync1_q;
        end
    end

    logic sCkT, sCkC, sCke, sCsN, sActN, sRasN, sCasN, sWeN, sOdt;
    logic [`DDRCA_BG_W-1:0] sBg;
    logic [`DDRCA_BA_W-1:0] sBa;
    logic [`DDRCA_ADDR_W-1:0] sAddr;
    logic [DQ_W-1:0] sDq;
    assign {sCkT, sCkC, sCke, sCsN, sActN, sRasN, sCasN, sWeN, sBg, sBa,
            sAddr, sOdt, sDq} = sync2_q;

    // ==========================================================
    // ck crossing detection
    logic ckLvl, ckPrev_q, ckRise, ckFall, ckEdge;
    assign ckLvl = sCkT & ~sCkC;
    assign ckRise = ckLvl & ~ckPrev_q;
    assign ckFall = ~ckLvl & ckPrev_q;
    assign ckEdge = ckRise | ckFall;
    always_ff @(posedge clk) begin
        if (srst) begin
            ckPrev_q <= 1'b0;
        end else begin
            ckPrev_q <= ckLvl;
        end
    end

    // ==========================================================
    // command decode
    ddrca_pwr_t pwr_q;
    ddrca_bst_t bst_q;
    ddrca_cmd_t cmd;
    logic ckePrev_q, cmdLive;
    logic [`DDRCA_BANKS-1:0] bankOpen_q;
    logic [3:0] cmdBank;
    logic [ROW_W-1:0] cmdRow;
    assign cmdBank = {sBg, sBa};
    assign cmdRow = {sCasN, sWeN, sAddr};
    // command buffers are off outside PWR_ON, so nothing decodes there
    assign cmdLive = ckRise && !sCsN && pwr_q == PWR_ON;
    always_comb begin
        cmd = CMD_NOP;
        if (cmdLive) begin
            if (!sActN) begin
                cmd = CMD_ACT;
            end else begin
                case ({sRasN, sCasN, sWeN})
                    3'h0: cmd = CMD_MRS;
                    3'h1: cmd = CMD_REF;
                    3'h2: cmd = CMD_PRE;
                    3'h4: cmd = CMD_WR;
                    3'h5: cmd = CMD_RD;
                    default: cmd = CMD_NOP;
                endcase
            end
        end
    end

    // ==========================================================
    // power state
    always_ff @(posedge clk) begin
        if (srst) begin
            ckePrev_q <= 1'b1;
        end else if (ckRise) begin
            ckePrev_q <= sCke;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_q <= PWR_ON;
        end else begin
            case (pwr_q)
                PWR_ON: begin
                    if (ckRise && !sCke && ckePrev_q) begin
                        if (cmd == CMD_REF && bankOpen_q == `DDRCA_BANKS_RST) begin
                            pwr_q <= PWR_SREF;
                        end else if (bankOpen_q == `DDRCA_BANKS_RST) begin
                            pwr_q <= PWR_PPD;
                        end else begin
                            pwr_q <= PWR_APD;
                        end
                    end
                end
                PWR_PPD, PWR_APD: begin
                    if (ckRise && sCke) begin
                        pwr_q <= PWR_ON;
                    end
                end
                PWR_SREF: begin
                    if (sCke) begin
                        pwr_q <= PWR_ON;
                    end
                end
                default: pwr_q <= PWR_ON;
            endcase
        end
    end

    logic intClkOn_q, cmdBufOn_q, ckBufOn_q, odtBufOn_q, odtSeen_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            intClkOn_q <= 1'b1;
            cmdBufOn_q <= 1'b1;
            ckBufOn_q <= 1'b1;
            odtBufOn_q <= 1'b1;
            odtSeen_q <= 1'b0;
        end else begin
            intClkOn_q <= pwr_q == PWR_ON;
            cmdBufOn_q <= pwr_q == PWR_ON;
            ckBufOn_q <= pwr_q != PWR_SREF;
            odtBufOn_q <= pwr_q != PWR_SREF;
            if (ckRise && pwr_q != PWR_SREF) begin
                odtSeen_q <= sOdt;
            end
        end
    end

    // ==========================================================
    // bank state
    logic [ROW_W-1:0] openRow_q [0:`DDRCA_BANKS-1];
    logic apNow;
    logic [3:0] bBank_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            bankOpen_q <= `DDRCA_BANKS_RST;
        end else begin
            if (apNow) begin
                bankOpen_q[bBank_q] <= 1'b0;
            end
            if (cmd == CMD_ACT) begin
                bankOpen_q[cmdBank] <= 1'b1;
            end else if (cmd == CMD_PRE) begin
                if (sAddr[`DDRCA_AP_BIT]) begin
                    bankOpen_q <= `DDRCA_BANKS_RST;
                end else begin
                    bankOpen_q[cmdBank] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (cmd == CMD_ACT) begin
            openRow_q[cmdBank] <= cmdRow;
        end
    end

    // ==========================================================
    // latency: AL is 0, CL-1 or CL-2
    logic [`DDRCA_LAT_W-1:0] alLat, rdLat, wrLat, preLen;
    always_comb begin
        case (alMode)
            AL_CL1: alLat = {2'h0, clLat} - 7'h01;
            AL_CL2: alLat = {2'h0, clLat} - 7'h02;
            default: alLat = 7'h00;
        endcase
    end
    assign rdLat = {2'h0, clLat} + alLat;
    assign wrLat = {2'h0, cwLat} + alLat;
    assign preLen = preambleTwo ? `DDRCA_PRE_TWO : `DDRCA_PRE_ONE;

    // ==========================================================
    // burst engine; a read or write during a burst is dropped
    logic bRead_q, bChop_q, bAp_q;
    logic [`DDRCA_COL_W-1:0] bCol_q, beat_q, beatIdx, beatCol;
    logic [`DDRCA_LAT_W-1:0] lat_q;
    logic [ROW_W-1:0] bRow_q;
    logic beatNow, lastBeat;
    assign beatNow = (bst_q == BST_DATA && ckEdge)
        || (bst_q == BST_WAIT && ckRise && lat_q == 7'h01);
    assign beatIdx = bst_q == BST_DATA ? beat_q : 3'h0;
    assign lastBeat = beatIdx == (bChop_q ? 3'h3 : 3'h7);
    assign apNow = beatNow && lastBeat && bAp_q;

    always_comb begin
        if (burstInterleave) begin
            beatCol = bCol_q ^ beatIdx;
        end else if (bChop_q) begin
            beatCol = {bCol_q[2], bCol_q[1:0] + beatIdx[1:0]};
        end else begin
            beatCol = bCol_q + beatIdx;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bst_q <= BST_IDLE;
            bRead_q <= 1'b0;
            bChop_q <= 1'b0;
            bAp_q <= 1'b0;
            bBank_q <= 4'h0;
            bCol_q <= 3'h0;
            bRow_q <= '0;
            lat_q <= 7'h00;
            beat_q <= 3'h0;
        end else begin
            case (bst_q)
                BST_IDLE: begin
                    if (cmd == CMD_RD || cmd == CMD_WR) begin
                        bst_q <= BST_WAIT;
                        bRead_q <= cmd == CMD_RD;
                        lat_q <= cmd == CMD_RD ? rdLat : wrLat;
                        bBank_q <= cmdBank;
                        bRow_q <= openRow_q[cmdBank];
                        bCol_q <= sAddr[`DDRCA_COL_W-1:0];
                        bAp_q <= sAddr[`DDRCA_AP_BIT];
                        bChop_q <= otfEnable ? !sAddr[`DDRCA_BC_BIT]
                                             : fixedChop;
                    end
                end
                BST_WAIT: begin
                    if (ckRise) begin
                        lat_q <= lat_q - 7'h01;
                        if (lat_q == 7'h01) begin
                            bst_q <= BST_DATA;
                            beat_q <= 3'h1;
                        end
                    end
                end
                BST_DATA: begin
                    if (ckEdge) begin
                        beat_q <= beat_q + 3'h1;
                        if (lastBeat) begin
                            bst_q <= BST_IDLE;
                        end
                    end
                end
                default: bst_q <= BST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // data path; a small array stands in for the cell array
    logic [DQ_W-1:0] mem_q [0:255];
    logic [7:0] memIdx;
    assign memIdx = {bBank_q, bRow_q[0], beatCol};
    always_ff @(posedge clk) begin
        if (beatNow && !bRead_q) begin
            mem_q[memIdx] <= sDq;
        end
    end

    logic [DQ_W-1:0] dqOut_q;
    logic dqOe_q, dqsOut_q, dqsOe_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            dqOut_q <= '0;
            dqOe_q <= 1'b0;
            dqsOut_q <= 1'b0;
            dqsOe_q <= 1'b0;
        end else if (beatNow && bRead_q && intClkOn_q) begin
            dqOut_q <= mem_q[memIdx];
            dqOe_q <= 1'b1;
            dqsOut_q <= ckRise;
            dqsOe_q <= 1'b1;
        end else if (bst_q == BST_WAIT && bRead_q && ckRise
                     && lat_q == preLen + 7'h01) begin
            dqsOut_q <= 1'b0;
            dqsOe_q <= 1'b1;
        end else if (ckEdge && bst_q == BST_IDLE) begin
            dqOe_q <= 1'b0;
            dqsOe_q <= 1'b0;
            dqsOut_q <= 1'b0;
        end
    end

    assign dqOut = dqOut_q;
    assign dqOe = dqOe_q;
    assign dqsOut = dqsOut_q;
    assign dqsOe = dqsOe_q;
    assign pwrState = pwr_q;
    assign bankOpen = bankOpen_q;
    assign intClkOn = intClkOn_q;
    assign cmdBufOn = cmdBufOn_q;
    assign ckBufOn = ckBufOn_q;
    assign odtBufOn = odtBufOn_q;
    assign odtSeen = odtSeen_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_cs_ignore: assert property (ckRise && sCsN && bst_q == BST_IDLE
        |=> bankOpen_q == $past(bankOpen_q)) else $error("cs high acted");
    a_act_opens: assert property (cmd == CMD_ACT
        |=> bankOpen_q[$past(cmdBank)]) else $error("act did not open");
    a_pre_all: assert property (cmd == CMD_PRE && sAddr[`DDRCA_AP_BIT]
        |=> bankOpen_q == `DDRCA_BANKS_RST) else $error("pre all failed");
    a_burst_len: assert property ($fell(bst_q == BST_DATA)
        |-> $past(beat_q) == ($past(bChop_q) ? 3'h3 : 3'h7))
        else $error("wrong burst length");
    a_rd_lat: assert property (cmd == CMD_RD && bst_q == BST_IDLE
        |=> bst_q == BST_WAIT && lat_q == $past(rdLat))
        else $error("read latency wrong");
    a_sref_exit: assert property (pwr_q == PWR_SREF && sCke
        |=> pwr_q == PWR_ON) else $error("self refresh exit missed");
    a_pd_entry: assert property (pwr_q == PWR_ON && ckRise && !sCke
        && ckePrev_q && cmd != CMD_REF |=> pwr_q == ($past(bankOpen_q) ==
        `DDRCA_BANKS_RST ? PWR_PPD : PWR_APD)) else $error("bad pd entry");
    a_sref_bufs: assert property (pwr_q == PWR_SREF
        |=> !cmdBufOn_q && !ckBufOn_q && !odtBufOn_q)
        else $error("buffers on in self refresh");
    a_pd_bufs: assert property (pwr_q == PWR_PPD || pwr_q == PWR_APD
        |=> !cmdBufOn_q && ckBufOn_q && odtBufOn_q)
        else $error("power down buffers wrong");
endmodule // ddrca_core
`default_nettype wire

// ==== ddrca_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host controller model: ck pair, command pins and write data
module ddrca_host_model (
    output logic ckT,
    output logic ckC,
    output logic cke,
    output logic csN,
    output logic actN,
    output logic rasN,
    output logic casN,
    output logic weN,
    output logic [1:0] bg,
    output logic [1:0] ba,
    output logic [13:0] addr,
    output logic odt,
    output logic [7:0] dqIn,
    input wire logic [7:0] dqOut,
    input wire logic dqOe,
    input wire logic dqsOut,
    input wire logic dqsOe
);
    // ck stands still outside command and tick calls
    int edgeN = 2;
    int wrAt = -99;
    logic [2:0] oeLog [0:2047];
    logic [7:0] dqLog [0:2047];

    // cke is only moved by the bench between accesses
    initial begin
        {ckT, ckC, cke, csN, actN, rasN, casN, weN} = 8'h7f;
        {bg, ba, addr, odt, dqIn} = '0;
    end

    // dq moves mid-way so the pin sync never sees it change at an edge
    task automatic half();
        int d;
        #40;
        oeLog[edgeN - 1] = {dqOe, dqsOe, dqsOut};
        dqLog[edgeN - 1] = dqOut;
        #40;
        d = edgeN + 1 - wrAt;
        if (d >= 0 && d < 8) dqIn = 8'ha0 + 8'(d);
        else dqIn = 8'h5a ^ 8'(edgeN);
        #80;
        ckT = ~ckT;
        ckC = ~ckC;
        edgeN++;
    endtask

    // a whole ck period per command covers row and precharge gaps
    task automatic cmd(input logic [3:0] arw, input logic [3:0] bank,
                       input logic [13:0] a, input logic sel,
                       output int at);
        {actN, rasN, casN, weN} = arw;
        {bg, ba} = bank;
        addr = a;
        csN = ~sel;
        half();
        at = edgeN;
        half();
        csN = 1;
        addr = ~a;
    endtask

    task automatic tick(input int n);
        repeat (2 * n) half();
    endtask
endmodule // ddrca_host_model
`default_nettype wire

// ==== ddrca_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench top
module ddrca_tb_top import ddrca_pkg::*;;
    logic clk, srst, ckT, ckC, cke, csN, actN, rasN, casN, weN, odt;
    logic dqOe, dqsOut, dqsOe, otfEnable, fixedChop, burstInterleave;
    logic preambleTwo, intClkOn, cmdBufOn, ckBufOn, odtBufOn, odtSeen;
    logic [1:0] bg, ba, alMode, pwrState;
    logic [13:0] addr;
    logic [7:0] dqIn, dqOut;
    logic [4:0] clLat, cwLat;
    logic [15:0] bankOpen;
    int errTotal = 0;
    int comparisons = 0;
    int cycles = 0;

    ddrca_core ddrca_core_i (
        .clk(clk), .srst(srst), .ckT(ckT), .ckC(ckC), .cke(cke),
        .csN(csN), .actN(actN), .rasN(rasN), .casN(casN), .weN(weN),
        .bg(bg), .ba(ba), .addr(addr), .odt(odt), .dqIn(dqIn),
        .dqOut(dqOut), .dqOe(dqOe), .dqsOut(dqsOut), .dqsOe(dqsOe),
        .clLat(clLat), .cwLat(cwLat), .alMode(alMode),
        .otfEnable(otfEnable), .fixedChop(fixedChop),
        .burstInterleave(burstInterleave), .preambleTwo(preambleTwo),
        .pwrState(pwrState), .bankOpen(bankOpen), .intClkOn(intClkOn),
        .cmdBufOn(cmdBufOn), .ckBufOn(ckBufOn), .odtBufOn(odtBufOn),
        .odtSeen(odtSeen)
    );

    ddrca_host_model ddrca_host_model_i (
        .ckT(ckT), .ckC(ckC), .cke(cke), .csN(csN), .actN(actN),
        .rasN(rasN), .casN(casN), .weN(weN), .bg(bg), .ba(ba),
        .addr(addr), .odt(odt), .dqIn(dqIn), .dqOut(dqOut),
        .dqOe(dqOe), .dqsOut(dqsOut), .dqsOe(dqsOe)
    );

    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    // ==========================================================
    // checking and closing
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (errTotal == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // a hang is cut well above the under a thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            errTotal++;
            end_of_test();
        end
    end

    // read bank 9 and compare every beat and strobe, and the preamble start
    task automatic rd(input logic [2:0] col, input logic ap,
                      input logic full, input int rl);
        int e;
        int n;
        int p;
        logic [2:0] c;
        n = full ? 8 : 4;
        p = preambleTwo ? 2 : 1;
        ddrca_host_model_i.cmd(4'hd, 4'h9,
            {1'b0, full, 1'b0, ap, 7'h0, col}, 1'b1, e);
        ddrca_host_model_i.tick(rl + 6);
        e += 2 * rl;
        chk(16'(ddrca_host_model_i.oeLog[e - 2 * p]), 16'h2);
        chk(16'(ddrca_host_model_i.oeLog[e - 2 * p - 1][1]), 16'h0);
        for (int k = 0; k < n; k++) begin
            if (burstInterleave) c = col ^ 3'(k);
            else if (full) c = col + 3'(k);
            else c = {col[2], col[1:0] + 2'(k)};
            chk(16'(ddrca_host_model_i.oeLog[e + k]),
                16'({2'b11, ~k[0]}));
            chk(16'(ddrca_host_model_i.dqLog[e + k]),
                16'(8'ha0 + 8'(c)));
        end
        chk(16'(ddrca_host_model_i.oeLog[e + n][2:1]), 16'h0);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        int e;
        srst = 1;
        clLat = 5'd2;
        cwLat = 5'd3;
        alMode = 2'd0;
        otfEnable = 1;
        fixedChop = 0;
        burstInterleave = 0;
        preambleTwo = 0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        srst = 0;
        chk(bankOpen, 16'h0);
        chk(16'({pwrState, intClkOn, cmdBufOn, ckBufOn, odtBufOn,
                 dqOe, dqsOe, odtSeen}), 16'h078);
        repeat (4) @(negedge clk);
        ddrca_host_model_i.cmd(4'h7, 4'h3, 14'h0, 1'b0, e);
        chk(bankOpen, 16'h0);
        // rows are opened before any column access
        ddrca_host_model_i.cmd(4'h7, 4'h9, 14'h2aa4, 1'b1, e);
        chk(bankOpen, 16'h0200);
        ddrca_host_model_i.cmd(4'h7, 4'h0, 14'h0, 1'b1, e);
        chk(bankOpen, 16'h0201);
        ddrca_host_model_i.cmd(4'hc, 4'h9, 14'h1000, 1'b1, e);
        ddrca_host_model_i.wrAt = e + 2 * int'(cwLat);
        ddrca_host_model_i.tick(8);
        rd(3'd3, 1'b0, 1'b1, 2);
        burstInterleave = 1;
        rd(3'd3, 1'b0, 1'b1, 2);
        burstInterleave = 0;
        rd(3'd5, 1'b0, 1'b0, 2);
        otfEnable = 0;
        fixedChop = 1;
        rd(3'd6, 1'b0, 1'b0, 2);
        fixedChop = 0;
        rd(3'd6, 1'b0, 1'b1, 2);
        otfEnable = 1;
        preambleTwo = 1;
        for (int i = 0; i < 3; i++) begin
            alMode = 2'(i);
            clLat = 5'(i == 0 ? 5 : i + 2);
            rd(3'd1, 1'b0, 1'b1, i == 2 ? 6 : 5);
        end
        alMode = 2'd0;
        clLat = 5'd2;
        preambleTwo = 0;
        ddrca_host_model_i.cmd(4'ha, 4'h9, 14'h0, 1'b1, e);
        chk(bankOpen, 16'h0001);
        ddrca_host_model_i.cmd(4'h7, 4'h9, 14'h0, 1'b1, e);
        rd(3'd0, 1'b1, 1'b1, 2);
        chk(bankOpen, 16'h0001);
        ddrca_host_model_i.cmd(4'h7, 4'h9, 14'h0, 1'b1, e);
        ddrca_host_model_i.cke = 0;
        ddrca_host_model_i.tick(1);
        chk(16'({pwrState, intClkOn, cmdBufOn, ckBufOn, odtBufOn}),
            16'h23);
        ddrca_host_model_i.cmd(4'ha, 4'h9, 14'h0400, 1'b1, e);
        chk(bankOpen, 16'h0201);
        ddrca_host_model_i.cke = 1;
        ddrca_host_model_i.tick(1);
        chk(16'(pwrState), 16'(PWR_ON));
        ddrca_host_model_i.cmd(4'ha, 4'h0, 14'h0400, 1'b1, e);
        chk(bankOpen, 16'h0);
        ddrca_host_model_i.cke = 0;
        ddrca_host_model_i.tick(1);
        chk(16'(pwrState), 16'(PWR_PPD));
        ddrca_host_model_i.cke = 1;
        ddrca_host_model_i.tick(1);
        ddrca_host_model_i.cke = 0;
        // one refresh, far inside the average interval
        ddrca_host_model_i.cmd(4'h9, 4'h0, 14'h0, 1'b1, e);
        chk(16'({pwrState, intClkOn, cmdBufOn, ckBufOn, odtBufOn}),
            16'h30);
        // ck stays still: exit must come from cke alone
        ddrca_host_model_i.cke = 1;
        for (int i = 0; i < 8 && pwrState !== 2'd0; i++) @(negedge clk);
        chk(16'(pwrState), 16'(PWR_ON));
        ddrca_host_model_i.odt = 1;
        ddrca_host_model_i.tick(1);
        chk(16'(odtSeen), 16'h1);
        end_of_test();
    end
endmodule // ddrca_tb_top
`default_nettype wire
